/* File: verilog/hscp_pkg.sv */
/*
  Shared constants of the host serial control port: frame layout, register
  map, reset values and timing counts. Assumes a 25 MHz core clock.
*/
package hscp_pkg;
  localparam int ADDR_W     = 7;
  localparam int DATA_W     = 8;
  localparam int CMD_BITS   = 1 + ADDR_W;
  localparam int WR_BITS    = CMD_BITS + DATA_W;
  localparam int WAIT_BITS  = 16;
  localparam int RD_DATA_AT = CMD_BITS + WAIT_BITS;
  localparam int RD_BITS    = RD_DATA_AT + DATA_W;
  localparam int CNT_W      = 6;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_STATUS = 7'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 7'h01;
  localparam logic [ADDR_W-1:0] OFS_EN_HI  = 7'h02;
  localparam logic [ADDR_W-1:0] OFS_EN_LO  = 7'h03;
  localparam logic [ADDR_W-1:0] OFS_ISR_HI = 7'h04;
  localparam logic [ADDR_W-1:0] OFS_ISR_LO = 7'h05;
  localparam int STS_READY_BIT = 7;
  localparam int CTL_PHY_RST_BIT = 0;
  localparam logic [DATA_W-1:0] CTRL_RST  = 8'h00;
  localparam logic [DATA_W-1:0] EN_HI_RST = 8'h00;
  localparam logic [DATA_W-1:0] EN_LO_RST = 8'h00;
  localparam logic [DATA_W-1:0] ISR_RST   = 8'h00;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CORE_CLK_NS  = 40;
  localparam int RST_MIN_NS   = 300;
  localparam int RST_MIN_CYC  = (RST_MIN_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
  localparam int RDY_WAIT_MS  = 5;
  localparam int RDY_WAIT_CYC = RDY_WAIT_MS * 1000000 / CORE_CLK_NS;
  localparam int INIT_NS      = 1000;
  localparam int INIT_CYC     = (INIT_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
  localparam int HALF_CYC     = 4;
endpackage

/* File: verilog/hscp_if.sv */
/*
  Pins between host and device. Resolves the pulled-up and open-drain
  wires from the output enables; nothing here is clocked.
*/
`timescale 1ns/1ps
interface hscp_if;
  logic       dev_rst_n;
  logic       sclk;
  logic       cs_n_o;
  logic       cs_oe;
  logic       mosi;
  logic       miso_o;
  logic       miso_oe;
  logic [1:0] int_o;
  logic [1:0] int_oe;
  logic       cs_n;
  logic       miso;
  logic [1:0] int_n;
  // undriven select and interrupts float high through the pull-ups
  assign cs_n  = cs_oe ? cs_n_o : 1'b1;
  assign miso  = miso_oe ? miso_o : 1'b1;
  assign int_n = (int_o | ~int_oe);
  modport dev_mp (input dev_rst_n, sclk, cs_n, mosi, output miso_o, miso_oe, int_o, int_oe);
  modport host_mp (output dev_rst_n, sclk, cs_n_o, cs_oe, mosi, input miso, int_n);
endinterface

/* File: verilog/hscp_sync3.sv */
/*
  Three-flop synchroniser with agreement filter, per bit.
  Assumes d comes from another clock domain or a pin.
*/
`timescale 1ns/1ps
module hscp_sync3 #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk,    // sampling clock
  input  wire logic         arst_n, // async reset, active low
  input  wire logic [W-1:0] d,      // foreign input
  output logic      [W-1:0] q       // filtered value
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      q    <= INIT;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // a change counts only once stages two and three agree
      q    <= (s3_q & ~(s2_q ^ s3_q)) | (q & (s2_q ^ s3_q));
    end
  end
endmodule

/* File: verilog/hscp_dev.sv */
/*
  Device end of the serial control port: frame parser on the host's serial
  clock, register file and interrupt logic on core_clk. Assumes the host
  frames every access with chip select and clocks the wait bits of a read.
*/
`timescale 1ns/1ps
module hscp_dev
  import hscp_pkg::*;
(
  input  wire logic              core_clk,        // core clock, 25 MHz
  hscp_if.dev_mp                 lk,              // serial port and interrupt pins
  input  wire logic [DATA_W-1:0] hi_event,        // high-priority status change pulses
  input  wire logic [DATA_W-1:0] lo_event,        // low-priority status change pulses
  output logic                   phy_reset_out_n, // phy reset, active low
  output logic                   dev_ready        // reset-ready flag copy
);
  logic              arst_n;
  logic [1:0]        rs_q;
  logic              core_rst_n;
  logic              frame_rst_n;
  logic [CNT_W-1:0]  cnt_q;
  logic [15:0]       sh_q;
  logic              rd_q;
  logic              req_q;
  logic              h_rd_q;
  logic [ADDR_W-1:0] h_addr_q;
  logic [DATA_W-1:0] h_wdata_q;
  logic              ack_s;
  logic [DATA_W-1:0] rd_load;
  logic [DATA_W-1:0] so_sh_q;
  logic              so_q;
  logic              so_oe_q;
  logic              req_s;
  logic              seen_q;
  logic              ack_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] ctl_q;
  logic [DATA_W-1:0] en_hi_q;
  logic [DATA_W-1:0] en_lo_q;
  logic [DATA_W-1:0] isr_hi_q;
  logic [DATA_W-1:0] isr_lo_q;
  logic [DATA_W-1:0] clr_hi;
  logic [DATA_W-1:0] clr_lo;
  logic [5:0]        init_q;
  logic              ready_q;
  logic              take;
  logic              wr_en;
  logic [1:0]        int_oe_q;
  logic              phy_q;

  function automatic logic is_wr(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    is_wr = wr_en && (a == ofs);
  endfunction

  assign arst_n = lk.dev_rst_n;

  // ---------------------------------------------------------------
  // reset release synchroniser for the core domain
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rs_q <= 2'h0;
    end else begin
      rs_q <= {rs_q[0], 1'b1};
    end
  end
  assign core_rst_n = rs_q[1];

  // ---------------------------------------------------------------
  // link domain: parser
  // ---------------------------------------------------------------
  assign frame_rst_n = arst_n & ~lk.cs_n;

  always_ff @(posedge lk.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      cnt_q <= '0;
      sh_q  <= 16'h0000;
      rd_q  <= 1'b0;
    end else begin
      if (cnt_q != '1) begin
        cnt_q <= cnt_q + 1'b1;
      end
      sh_q <= {sh_q[14:0], lk.mosi};
      if (cnt_q == '0) begin
        rd_q <= lk.mosi;
      end
    end
  end

  // request words survive the end of the frame, so only device reset clears them
  always_ff @(posedge lk.sclk or negedge arst_n) begin
    if (!arst_n) begin
      req_q     <= 1'b0;
      h_rd_q    <= 1'b0;
      h_addr_q  <= '0;
      h_wdata_q <= '0;
    end else if (!lk.cs_n) begin
      if (rd_q && cnt_q == CNT_W'(CMD_BITS - 1)) begin
        h_rd_q   <= 1'b1;
        h_addr_q <= {sh_q[5:0], lk.mosi};
        req_q    <= ~req_q;
      end else if (!rd_q && cnt_q == CNT_W'(WR_BITS - 1)) begin
        h_rd_q    <= 1'b0;
        h_addr_q  <= sh_q[13:7];
        h_wdata_q <= {sh_q[6:0], lk.mosi};
        req_q     <= ~req_q;
      end
    end
  end

  hscp_sync3 #(.W(1), .INIT(1'b0)) u_ack_sync (
    .clk    (lk.sclk),
    .arst_n (arst_n),
    .d      (ack_q),
    .q      (ack_s)
  );

  // a late answer reads as zero rather than stale data
  assign rd_load = (ack_s == req_q) ? rdata_q : '0;

  // ---------------------------------------------------------------
  // link domain: serial output, changes on the falling edge
  // ---------------------------------------------------------------
  always_ff @(negedge lk.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      so_q    <= 1'b1;
      so_oe_q <= 1'b0;
      so_sh_q <= '0;
    end else if (rd_q) begin
      if (cnt_q == CNT_W'(RD_DATA_AT)) begin
        so_oe_q <= 1'b1;
        so_q    <= rd_load[DATA_W-1];
        so_sh_q <= {rd_load[DATA_W-2:0], 1'b0};
      end else if (cnt_q > CNT_W'(RD_DATA_AT) && cnt_q < CNT_W'(RD_BITS)) begin
        so_q    <= so_sh_q[DATA_W-1];
        so_sh_q <= {so_sh_q[DATA_W-2:0], 1'b0};
      end else if (cnt_q == CNT_W'(RD_BITS)) begin
        so_oe_q <= 1'b0;
        so_q    <= 1'b1;
      end
    end
  end
  assign lk.miso_o  = so_q;
  assign lk.miso_oe = so_oe_q;

  // ---------------------------------------------------------------
  // core domain: request handshake
  // ---------------------------------------------------------------
  hscp_sync3 #(.W(1), .INIT(1'b0)) u_req_sync (
    .clk    (core_clk),
    .arst_n (core_rst_n),
    .d      (req_q),
    .q      (req_s)
  );
  assign take  = (req_s != seen_q);
  // writes before the ready flag are dropped; reads still answer for polling
  assign wr_en = take && !h_rd_q && ready_q;

  always_ff @(posedge core_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      seen_q  <= 1'b0;
      ack_q   <= 1'b0;
      rdata_q <= '0;
    end else if (take) begin
      seen_q <= req_s;
      if (h_rd_q) begin
        unique case (h_addr_q)
          OFS_STATUS: rdata_q <= {ready_q, 7'h00};
          OFS_CTRL:   rdata_q <= ctl_q;
          OFS_EN_HI:  rdata_q <= en_hi_q;
          OFS_EN_LO:  rdata_q <= en_lo_q;
          OFS_ISR_HI: rdata_q <= isr_hi_q;
          OFS_ISR_LO: rdata_q <= isr_lo_q;
          default:    rdata_q <= '0;
        endcase
      end
      // every request is answered, writes too, so req and ack toggles stay paired
      ack_q <= ~ack_q;
    end
  end

  // ---------------------------------------------------------------
  // core domain: registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      ctl_q   <= CTRL_RST;
      en_hi_q <= EN_HI_RST;
      en_lo_q <= EN_LO_RST;
    end else begin
      if (is_wr(h_addr_q, OFS_CTRL)) begin
        ctl_q <= h_wdata_q;
      end
      if (is_wr(h_addr_q, OFS_EN_HI)) begin
        en_hi_q <= h_wdata_q;
      end
      if (is_wr(h_addr_q, OFS_EN_LO)) begin
        en_lo_q <= h_wdata_q;
      end
    end
  end

  // service registers clear by writing ones; a new event wins
  assign clr_hi = is_wr(h_addr_q, OFS_ISR_HI) ? h_wdata_q : '0;
  assign clr_lo = is_wr(h_addr_q, OFS_ISR_LO) ? h_wdata_q : '0;

  always_ff @(posedge core_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      isr_hi_q <= ISR_RST;
      isr_lo_q <= ISR_RST;
    end else begin
      isr_hi_q <= (isr_hi_q & ~clr_hi) | hi_event;
      isr_lo_q <= (isr_lo_q & ~clr_lo) | lo_event;
    end
  end

  always_ff @(posedge core_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      init_q  <= 6'h00;
      ready_q <= 1'b0;
    end else if (init_q == 6'(INIT_CYC - 1)) begin
      ready_q <= 1'b1;
    end else begin
      init_q <= init_q + 6'h01;
    end
  end

  // ---------------------------------------------------------------
  // pins: interrupts and phy reset
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      int_oe_q <= 2'h0;
      phy_q    <= 1'b0;
    end else begin
      int_oe_q[0] <= |(isr_hi_q & en_hi_q);
      int_oe_q[1] <= |(isr_lo_q & en_lo_q);
      phy_q       <= ~ctl_q[CTL_PHY_RST_BIT];
    end
  end
  assign lk.int_o         = 2'h0;
  assign lk.int_oe        = int_oe_q;
  assign phy_reset_out_n  = phy_q;
  assign dev_ready        = ready_q;
endmodule

/* File: verilog/hscp_host.sv */
/*
  Host end of the serial control port: resets the device, waits for ready,
  then runs one register access per command. Makes the serial clock by
  dividing core_clk. Assumes the device end on the far side of hscp_if.
*/
`timescale 1ns/1ps
module hscp_host
  import hscp_pkg::*;
#(
  parameter int RDY_WAIT = RDY_WAIT_CYC
) (
  input  wire logic              core_clk,  // core clock, 25 MHz
  input  wire logic              arst_n,    // async reset, active low
  hscp_if.host_mp                lk,        // serial port pins
  input  wire logic              cmd_valid, // access request
  output logic                   cmd_ready, // request taken when both high
  input  wire logic              cmd_rd,    // 1 read, 0 write
  input  wire logic [ADDR_W-1:0] cmd_addr,  // register address
  input  wire logic [DATA_W-1:0] cmd_wdata, // write data
  output logic                   rsp_valid, // one-cycle completion pulse
  output logic      [DATA_W-1:0] rsp_rdata, // read data, zero for writes
  output logic                   dev_ready, // device accessible
  output logic                   int_hi,    // high-priority interrupt seen
  output logic                   int_lo     // low-priority interrupt seen
);
  typedef enum logic [2:0] {
    ST_RST  = 3'b000,
    ST_POLL = 3'b001,
    ST_IDLE = 3'b010,
    ST_XFER = 3'b011,
    ST_TAIL = 3'b100
  } hscp_st_t;

  hscp_st_t          st_q;
  logic [2:0]        pin_s;
  logic [16:0]       tmo_q;
  logic              tmo_hit;
  logic [3:0]        rcnt_q;
  logic [2:0]        half_q;
  logic [CNT_W-1:0]  per_q;
  logic [15:0]       tx_q;
  logic [DATA_W-1:0] rx_q;
  logic              xrd_q;
  logic              xpoll_q;
  logic              rst_n_q;
  logic              sclk_q;
  logic              cs_n_q;
  logic              cs_oe_q;
  logic              half_end;
  logic [CNT_W-1:0]  last_per;

  hscp_sync3 #(.W(3), .INIT(3'h7)) u_pin_sync (
    .clk    (core_clk),
    .arst_n (arst_n),
    .d      ({lk.miso, lk.int_n}),
    .q      (pin_s)
  );

  assign half_end = (half_q == 3'(HALF_CYC - 1));
  assign last_per = xrd_q ? CNT_W'(RD_BITS - 1) : CNT_W'(WR_BITS - 1);
  assign tmo_hit  = (tmo_q == 17'(RDY_WAIT));

  // ---------------------------------------------------------------
  // ready timeout, as a fallback to polling
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tmo_q <= 17'h00000;
    end else if (rst_n_q && !dev_ready && !tmo_hit) begin
      tmo_q <= tmo_q + 17'h00001;
    end
  end

  // ---------------------------------------------------------------
  // sequencer and serial engine
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q      <= ST_RST;
      rcnt_q    <= 4'h0;
      half_q    <= 3'h0;
      per_q     <= '0;
      tx_q      <= 16'h0000;
      rx_q      <= '0;
      xrd_q     <= 1'b0;
      xpoll_q   <= 1'b0;
      rst_n_q   <= 1'b0;
      sclk_q    <= 1'b0;
      cs_n_q    <= 1'b1;
      cs_oe_q   <= 1'b0;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      dev_ready <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      cs_oe_q   <= 1'b1;
      unique case (st_q)
        ST_RST: begin
          if (rcnt_q == 4'(RST_MIN_CYC - 1)) begin
            rst_n_q <= 1'b1;
            st_q    <= ST_POLL;
          end else begin
            rcnt_q <= rcnt_q + 4'h1;
          end
        end
        ST_POLL: begin
          tx_q    <= {1'b1, OFS_STATUS, 8'h00};
          xrd_q   <= 1'b1;
          xpoll_q <= 1'b1;
          per_q   <= '0;
          half_q  <= 3'h0;
          cs_n_q  <= 1'b0;
          st_q    <= ST_XFER;
        end
        ST_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            tx_q      <= {cmd_rd, cmd_addr, cmd_rd ? 8'h00 : cmd_wdata};
            xrd_q     <= cmd_rd;
            xpoll_q   <= 1'b0;
            per_q     <= '0;
            half_q    <= 3'h0;
            cs_n_q    <= 1'b0;
            st_q      <= ST_XFER;
          end
        end
        ST_XFER: begin
          half_q <= half_end ? 3'h0 : half_q + 3'h1;
          if (half_end && !sclk_q) begin
            sclk_q <= 1'b1;
          end else if (half_end) begin
            sclk_q <= 1'b0;
            if (xrd_q && per_q >= CNT_W'(RD_DATA_AT)) begin
              rx_q <= {rx_q[DATA_W-2:0], pin_s[2]};
            end
            if (per_q == last_per) begin
              st_q <= ST_TAIL;
            end else begin
              per_q <= per_q + 1'b1;
              tx_q  <= {tx_q[14:0], 1'b0};
            end
          end
        end
        ST_TAIL: begin
          half_q <= half_q + 3'h1;
          if (half_end) begin
            cs_n_q <= 1'b1;
            if (!xpoll_q) begin
              rsp_valid <= 1'b1;
              rsp_rdata <= xrd_q ? rx_q : '0;
              cmd_ready <= 1'b1;
              st_q      <= ST_IDLE;
            end else if (rx_q[STS_READY_BIT] || tmo_hit) begin
              dev_ready <= 1'b1;
              cmd_ready <= 1'b1;
              st_q      <= ST_IDLE;
            end else begin
              st_q <= ST_POLL;
            end
          end
        end
      endcase
    end
  end

  // interrupt lines are raw; the user reads the service registers on them
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      int_hi <= 1'b0;
      int_lo <= 1'b0;
    end else begin
      int_hi <= ~pin_s[0];
      int_lo <= ~pin_s[1];
    end
  end

  assign lk.dev_rst_n = rst_n_q;
  assign lk.sclk      = sclk_q;
  assign lk.cs_n_o    = cs_n_q;
  assign lk.cs_oe     = cs_oe_q;
  assign lk.mosi      = tx_q[15];
endmodule

/* File: sim/hscp_chk.sv */
/*
  Pin-level assertions of the host serial control port.
  Assumes it stands beside hscp_if in the bench and sees core_clk and the host reset.
*/
`timescale 1ns/1ps
module hscp_chk
  import hscp_pkg::*;
(
  input  wire logic       core_clk,  // core clock
  input  wire logic       arst_n,    // host reset, active low
  input  wire logic       dev_rst_n, // device reset pin
  input  wire logic       sclk,      // serial clock
  input  wire logic       cs_n,      // resolved select
  input  wire logic       mosi,      // host serial data
  input  wire logic       miso_oe,   // device drives serial output
  input  wire logic [1:0] int_oe,    // device pulls interrupt low
  input  wire logic [1:0] int_n      // resolved interrupt pins
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // ---------------------------------------------------------------
  // device reset low time
  // ---------------------------------------------------------------
  // saturates so a long reset never wraps into a short one
  logic [7:0] low_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      low_q <= 8'h00;
    end else if (dev_rst_n) begin
      low_q <= 8'h00;
    end else if (low_q != 8'hFF) begin
      low_q <= low_q + 8'h01;
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  a_rst_min_low: assert property ($rose(dev_rst_n) |-> low_q >= RST_MIN_CYC)
    else $error("device reset released too early");
  a_rst_pins_quiet: assert property (!dev_rst_n |-> int_oe == 2'b00 && !miso_oe)
    else $error("device drives pins while in reset");
  a_frame_start: assert property ($fell(cs_n) |-> !sclk [*4] ##1 sclk)
    else $error("serial clock not low for a half period after select");
  a_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("serial clock runs outside a frame");
  a_miso_in_frame: assert property (miso_oe |-> !cs_n)
    else $error("serial output driven while not selected");
  a_miso_hold: assert property ($rose(miso_oe) |-> miso_oe [*8])
    else $error("read data drive too short");
  a_mosi_low_half: assert property ($changed(mosi) |-> !sclk)
    else $error("serial input changed while clock high");
  a_int_open_drain: assert property (int_n == ~int_oe)
    else $error("interrupt pin not open drain active low");
  c_read: cover property ($rose(miso_oe));
  c_int_hi: cover property ($fell(int_n[0]));
  c_int_lo: cover property ($fell(int_n[1]));
  c_dev_rst: cover property ($rose(dev_rst_n));
endmodule

/* File: sim/host_serial_control_port_tb.sv */
/*
  Self-checking bench: host and device ends joined by hscp_if, driven through
  the host command port and compared with a register model. Needs the hscp design.
*/
`timescale 1ns/1ps
module host_serial_control_port_tb
  import hscp_pkg::*;
;
  logic              core_clk;
  logic              arst_n;
  logic              cmd_valid;
  logic              cmd_ready;
  logic              cmd_rd;
  logic [ADDR_W-1:0] cmd_addr;
  logic [DATA_W-1:0] cmd_wdata;
  logic              rsp_valid;
  logic [DATA_W-1:0] rsp_rdata;
  logic              host_ready;
  logic              dev_ready;
  logic              int_hi;
  logic              int_lo;
  logic [DATA_W-1:0] hi_event;
  logic [DATA_W-1:0] lo_event;
  logic              phy_reset_out_n;
  logic [15:0]       lfsr_q;
  int                n_errors;
  int                n_checks;
  int                reg_m [0:7];
  hscp_if lk_if ();
  hscp_dev u_hscp_dev (
    .core_clk        (core_clk),
    .lk              (lk_if),
    .hi_event        (hi_event),
    .lo_event        (lo_event),
    .phy_reset_out_n (phy_reset_out_n),
    .dev_ready       (dev_ready)
  );
  // short ready wait: the 200 cycles run out during the first status poll, whose frame also returns the device flag
  hscp_host #(.RDY_WAIT(200)) u_hscp_host (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .lk        (lk_if),
    .cmd_valid (cmd_valid),
    .cmd_ready (cmd_ready),
    .cmd_rd    (cmd_rd),
    .cmd_addr  (cmd_addr),
    .cmd_wdata (cmd_wdata),
    .rsp_valid (rsp_valid),
    .rsp_rdata (rsp_rdata),
    .dev_ready (host_ready),
    .int_hi    (int_hi),
    .int_lo    (int_lo)
  );
  hscp_chk u_hscp_chk (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .dev_rst_n (lk_if.dev_rst_n),
    .sclk      (lk_if.sclk),
    .cs_n      (lk_if.cs_n),
    .mosi      (lk_if.mosi),
    .miso_oe   (lk_if.miso_oe),
    .int_oe    (lk_if.int_oe),
    .int_n     (lk_if.int_n)
  );
  always #20 core_clk = ~core_clk;
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (n_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // request held until the edge that takes it; data sampled mid-cycle
  task automatic access(input logic rd, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
    int k;
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_rd    <= rd;
    cmd_addr  <= a;
    cmd_wdata <= d;
    k = 0;
    @(negedge core_clk);
    while (cmd_ready !== 1'b1 && k < 400) begin
      @(negedge core_clk);
      k++;
    end
    check(cmd_ready, 8'h01);
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    k = 0;
    @(negedge core_clk);
    while (rsp_valid !== 1'b1 && k < 400) begin
      @(negedge core_clk);
      k++;
    end
    check(rsp_valid, 8'h01);
    q = rsp_rdata;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    access(1'b0, a, d, q);
    check(q, 8'h00);
    if (a >= 1 && a <= 3) reg_m[a] = d;
    if (a == 4 || a == 5) reg_m[a] = reg_m[a] & ~d;
  endtask
  task automatic rd_chk(input logic [6:0] a);
    logic [7:0] q;
    int         e;
    access(1'b1, a, 8'h00, q);
    e = (a == 0) ? 8'h80 : (a <= 5) ? reg_m[a] : 0;
    check(q, e[7:0]);
  endtask
  task automatic do_reset();
    int k;
    @(posedge core_clk);
    arst_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    check(lk_if.dev_rst_n, 8'h00);
    check(phy_reset_out_n, 8'h00);
    check(lk_if.cs_n, 8'h01);
    arst_n <= 1'b1;
    foreach (reg_m[i]) reg_m[i] = 0;
    k = 0;
    while (host_ready !== 1'b1 && k < 3000) begin
      @(posedge core_clk);
      k++;
    end
    check(host_ready, 8'h01);
    check(dev_ready, 8'h01);
    check(phy_reset_out_n, 8'h01);
  endtask
  task automatic fire(input int p, input logic [7:0] ev);
    @(posedge core_clk);
    if (p == 0) hi_event <= ev;
    else lo_event <= ev;
    repeat (6) @(posedge core_clk);
    hi_event <= 8'h00;
    lo_event <= 8'h00;
    repeat (12) @(posedge core_clk);
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] ev;
    logic [7:0] en;
    arst_n    = 1'b0;
    core_clk  = 1'b0;
    cmd_valid = 1'b0;
    cmd_rd    = 1'b0;
    cmd_addr  = '0;
    cmd_wdata = '0;
    hi_event  = '0;
    lo_event  = '0;
    n_errors  = 0;
    n_checks  = 0;
    lfsr_q    = 16'hE5FC;
    do_reset();
    for (int a = 0; a < 6; a++) rd_chk(a[6:0]);
    wr(OFS_STATUS, 8'h00);
    wr(7'h40, 8'hFF);
    rd_chk(OFS_STATUS);
    rd_chk(7'h40);
    wr(OFS_CTRL, 8'h01);
    rd_chk(OFS_CTRL);
    check(phy_reset_out_n, 8'h00);
    for (int p = 0; p < 2; p++) begin
      for (int j = 0; j < 3; j++) begin
        lfsr_q = lfsr_next(lfsr_q);
        ev = lfsr_q[7:0] | 8'h01;
        lfsr_q = lfsr_next(lfsr_q);
        en = (j == 0) ? ~ev : (j == 1) ? ev : lfsr_q[7:0];
        wr(p ? OFS_EN_LO : OFS_EN_HI, en);
        fire(p, ev);
        reg_m[4+p] = reg_m[4+p] | ev;
        check(p ? int_lo : int_hi, {7'h00, |(ev & en)});
        check(p ? int_hi : int_lo, 8'h00);
        check(lk_if.int_n[p], {7'h00, ~|(ev & en)});
        rd_chk(p ? OFS_ISR_LO : OFS_ISR_HI);
        wr(p ? OFS_ISR_LO : OFS_ISR_HI, ev);
        repeat (12) @(posedge core_clk);
        check(p ? int_lo : int_hi, 8'h00);
        rd_chk(p ? OFS_ISR_LO : OFS_ISR_HI);
      end
    end
    wr(OFS_EN_HI, 8'hFF);
    do_reset();
    for (int a = 1; a < 6; a++) rd_chk(a[6:0]);
    conclude();
  end
  initial begin
    #(40 * 30000);
    n_errors++;
    conclude();
  end
endmodule
